/* File: hdl/sfc_pkg.sv */
// constants for the flash command interpreter
package sfc_pkg;
  // opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT_RD = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT_RD = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO_RD = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO_RD = 8'hEB;
  localparam logic [7:0] OP_PARAM_RD = 8'h5A;
  localparam logic [7:0] OP_JEDEC_ID = 8'h9F;
  localparam logic [7:0] OP_MAKER_ID = 8'h90;
  localparam logic [7:0] OP_DUAL_MAKER_ID = 8'h92;
  localparam logic [7:0] OP_QUAD_MAKER_ID = 8'h94;
  localparam logic [7:0] OP_OTP_RD = 8'h48;
  localparam logic [7:0] OP_BURST_SET = 8'h77;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_RESUME_A = 8'h7A;
  localparam logic [7:0] OP_RESUME_B = 8'h30;
  localparam logic [7:0] OP_SUSPEND_A = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B = 8'hB0;
  localparam logic [7:0] OP_PAGE_PGM = 8'h02;
  localparam logic [7:0] OP_DUAL_PGM = 8'hA2;
  localparam logic [7:0] OP_QUAD_PGM = 8'h32;
  localparam logic [7:0] OP_STAT_LO = 8'h05;
  localparam logic [7:0] OP_STAT_HI = 8'h35;
  localparam logic [7:0] OP_ASYNC_IF = 8'h25;
  localparam logic [7:0] OP_SIGNATURE = 8'hAB;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_NO_OP = 8'h00;
  localparam logic [7:0] OP_SERIAL_NUM = 8'h4B;
  // status word bit positions
  localparam int ST_WIP_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_ERS_SUS_BIT = 10;
  localparam int ST_PGM_SUS_BIT = 15;
  // framing counts
  localparam logic [3:0] OPCODE_BITS = 4'h8;
  localparam logic [5:0] SERIAL_DUMMY_BITS = 6'h20;
  // suspend latencies
  localparam int CLK_MHZ = 100;
  localparam int PGM_SUS_LAT_NS = 20000;
  localparam int ERS_SUS_LAT_NS = 20000;
  localparam int PGM_SUS_LAT_CYC = (PGM_SUS_LAT_NS * CLK_MHZ + 999) / 1000;
  localparam int ERS_SUS_LAT_CYC = (ERS_SUS_LAT_NS * CLK_MHZ + 999) / 1000;
  // operation states, gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BUSY = 3'h1,
    ST_SUS_WAIT = 3'h3,
    ST_SUSPENDED = 3'h2,
    ST_SUS_PGM = 3'h6
  } sfc_state_e;
endpackage

/* File: hdl/sfc_cmd_core.sv */
// serial flash id, suspend/resume and software reset command logic
// Operation
// - identity opcode shifts out 24 id bits
// - identity opcode ignored while program/erase busy
// - select rising returns to standby
// - suspended region excluded from array reads
// - suspend latency then clear latch, set flag
// - status bit 15 program, bit 10 erase suspend
// - reads, ids, resume accepted after latency
// - enable and page program only in erase suspend
// - any-time commands accepted without latency
// - suspended sector excluded from suspend programming
// - suspend-program not suspendable, blocks resume
// - latch and busy stay set during suspend-program
// - resume sets latch and busy, clears flag
// - no-operation only cancels armed reset
// - reset only directly after reset arm
// - software reset restores power-on defaults
// - software reset aborts running operation
// - serial number after four dummy bytes
// - output msb first on falling clock edge
`timescale 1ns/1ps
`default_nettype none
module sfc_cmd_core #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h1234, // arbitrary value
  parameter logic [127:0] SERIAL_NUMBER = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
)(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // serial pins
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  // array engine
  input wire logic i_ers_start,
  input wire logic i_op_done,
  output logic o_pgm_go,
  output logic o_suspend_go,
  output logic o_resume_go,
  output logic o_abort,
  output logic o_array_read,
  output logic o_guard_region,
  // status
  output logic [15:0] o_status,
  output logic o_write_enable_latch,
  output logic o_write_in_progress
);
  // ******************************
  // pin synchronisers
  // ******************************
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic ck_s1_r, ck_s2_r, ck_s3_r;
  logic si_s1_r, si_s2_r;
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      {cs_s1_r, cs_s2_r, cs_s3_r} <= 3'h7;
      {ck_s1_r, ck_s2_r, ck_s3_r} <= 3'h0;
      {si_s1_r, si_s2_r} <= 2'h0;
    end
    else
    begin
      {cs_s1_r, cs_s2_r, cs_s3_r} <= {i_cs_n, cs_s1_r, cs_s2_r};
      {ck_s1_r, ck_s2_r, ck_s3_r} <= {i_sclk, ck_s1_r, ck_s2_r};
      {si_s1_r, si_s2_r} <= {i_si, si_s1_r};
    end
  end
  logic sel, cs_rise, ck_rise, ck_fall;
  assign sel = !cs_s2_r;
  assign cs_rise = cs_s2_r && !cs_s3_r;
  assign ck_rise = sel && ck_s2_r && !ck_s3_r;
  assign ck_fall = sel && !ck_s2_r && ck_s3_r;

  // ******************************
  // acceptance decode
  // ******************************
  function automatic logic is_any_time(input logic [7:0] op);
    is_any_time = op == sfc_pkg::OP_WR_DISABLE || op == sfc_pkg::OP_STAT_LO
      || op == sfc_pkg::OP_STAT_HI || op == sfc_pkg::OP_ASYNC_IF
      || op == sfc_pkg::OP_SIGNATURE || op == sfc_pkg::OP_RESET_ARM
      || op == sfc_pkg::OP_RESET || op == sfc_pkg::OP_NO_OP;
  endfunction
  function automatic logic is_array_read(input logic [7:0] op);
    is_array_read = op == sfc_pkg::OP_READ || op == sfc_pkg::OP_FAST_READ
      || op == sfc_pkg::OP_DUAL_OUT_RD || op == sfc_pkg::OP_QUAD_OUT_RD
      || op == sfc_pkg::OP_DUAL_IO_RD || op == sfc_pkg::OP_QUAD_IO_RD;
  endfunction
  function automatic logic is_sus_read(input logic [7:0] op);
    is_sus_read = is_array_read(op) || op == sfc_pkg::OP_PARAM_RD
      || op == sfc_pkg::OP_JEDEC_ID || op == sfc_pkg::OP_MAKER_ID
      || op == sfc_pkg::OP_DUAL_MAKER_ID || op == sfc_pkg::OP_QUAD_MAKER_ID
      || op == sfc_pkg::OP_OTP_RD || op == sfc_pkg::OP_BURST_SET;
  endfunction
  function automatic logic is_pgm(input logic [7:0] op);
    is_pgm = op == sfc_pkg::OP_PAGE_PGM || op == sfc_pkg::OP_DUAL_PGM
      || op == sfc_pkg::OP_QUAD_PGM;
  endfunction
  function automatic logic is_sus(input logic [7:0] op);
    is_sus = op == sfc_pkg::OP_SUSPEND_A || op == sfc_pkg::OP_SUSPEND_B;
  endfunction
  function automatic logic is_res(input logic [7:0] op);
    is_res = op == sfc_pkg::OP_RESUME_A || op == sfc_pkg::OP_RESUME_B;
  endfunction

  sfc_pkg::sfc_state_e st_r;
  logic ers_r;
  function automatic logic accept(input logic [7:0] op);
    case (st_r)
      sfc_pkg::ST_IDLE: accept = !is_sus(op) && !is_res(op);
      sfc_pkg::ST_BUSY: accept = is_any_time(op) || is_sus(op);
      sfc_pkg::ST_SUS_WAIT: accept = is_any_time(op);
      sfc_pkg::ST_SUSPENDED: accept = is_any_time(op) || is_sus_read(op)
        || is_res(op)
        || (ers_r && (is_pgm(op) || op == sfc_pkg::OP_WR_ENABLE));
      sfc_pkg::ST_SUS_PGM: accept = is_any_time(op);
      default: accept = 1'b0;
    endcase
  endfunction

  // ******************************
  // opcode capture
  // ******************************
  logic [3:0] bit_cnt_r;
  logic [7:0] op_sh_r;
  logic [7:0] cmd_r;
  logic cmd_ok_r;
  logic dec_p, ex_p;
  logic [7:0] op_now;
  assign op_now = {op_sh_r[6:0], si_s2_r};
  assign dec_p = ck_rise && bit_cnt_r == sfc_pkg::OPCODE_BITS - 4'h1;
  assign ex_p = cs_rise && cmd_ok_r;
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bit_cnt_r <= 4'h0;
      op_sh_r <= 8'h00;
      cmd_r <= 8'h00;
      cmd_ok_r <= 1'b0;
    end
    else if (!sel)
    begin
      bit_cnt_r <= 4'h0;
      cmd_ok_r <= 1'b0;
    end
    else if (ck_rise && bit_cnt_r < sfc_pkg::OPCODE_BITS)
    begin
      op_sh_r <= op_now;
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (dec_p)
      begin
        cmd_r <= op_now;
        cmd_ok_r <= accept(op_now);
      end
    end
  end

  // ******************************
  // serial output
  // ******************************
  logic [127:0] tx_r;
  logic [5:0] dum_r;
  logic out_en_r;
  logic so_r;
  logic [15:0] status;
  logic go_out;
  always_comb
  begin
    go_out = dec_p && accept(op_now) && (op_now == sfc_pkg::OP_JEDEC_ID
      || op_now == sfc_pkg::OP_SERIAL_NUM || op_now == sfc_pkg::OP_STAT_LO
      || op_now == sfc_pkg::OP_STAT_HI);
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_r <= 128'h0;
      dum_r <= 6'h00;
      out_en_r <= 1'b0;
      so_r <= 1'b0;
    end
    else if (!sel)
    begin
      out_en_r <= 1'b0;
      dum_r <= 6'h00;
    end
    else if (go_out)
    begin
      out_en_r <= 1'b1;
      dum_r <= 6'h00;
      case (op_now)
        sfc_pkg::OP_JEDEC_ID:
          tx_r <= {MAKER_CODE, DEVICE_CODE, 104'h0};
        sfc_pkg::OP_SERIAL_NUM:
        begin
          tx_r <= SERIAL_NUMBER;
          dum_r <= sfc_pkg::SERIAL_DUMMY_BITS;
        end
        sfc_pkg::OP_STAT_LO: tx_r <= {16{status[7:0]}};
        default: tx_r <= {16{status[15:8]}};
      endcase
    end
    else if (ck_rise && dum_r != 6'h00)
      dum_r <= dum_r - 6'h01;
    else if (ck_fall && out_en_r && dum_r == 6'h00)
    begin
      so_r <= tx_r[127];
      tx_r <= {tx_r[126:0], 1'b0};
    end
  end
  assign o_so = so_r;
  assign o_so_oe_n = !(out_en_r && sel && dum_r == 6'h00);

  // ******************************
  // operation state
  // ******************************
  logic wel_r, armed_r;
  logic [11:0] lat_r;
  logic [11:0] lat_end;
  logic soft_rst;
  assign lat_end = ers_r ? 12'(sfc_pkg::ERS_SUS_LAT_CYC - 1)
    : 12'(sfc_pkg::PGM_SUS_LAT_CYC - 1);
  assign soft_rst = ex_p && cmd_r == sfc_pkg::OP_RESET && armed_r;
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      armed_r <= 1'b0;
    else if (ex_p)
      armed_r <= cmd_r == sfc_pkg::OP_RESET_ARM;
    else if (cs_rise)
      armed_r <= 1'b0;
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r <= sfc_pkg::ST_IDLE;
      ers_r <= 1'b0;
      wel_r <= 1'b0;
      lat_r <= 12'h000;
    end
    else if (soft_rst)
    begin
      st_r <= sfc_pkg::ST_IDLE;
      ers_r <= 1'b0;
      wel_r <= 1'b0;
      lat_r <= 12'h000;
    end
    else
    begin
      case (st_r)
        sfc_pkg::ST_IDLE:
          if (i_ers_start && wel_r)
          begin
            st_r <= sfc_pkg::ST_BUSY;
            ers_r <= 1'b1;
          end
          else if (ex_p && is_pgm(cmd_r) && wel_r)
          begin
            st_r <= sfc_pkg::ST_BUSY;
            ers_r <= 1'b0;
          end
        sfc_pkg::ST_BUSY:
          if (i_op_done)
          begin
            st_r <= sfc_pkg::ST_IDLE;
            wel_r <= 1'b0;
          end
          else if (ex_p && is_sus(cmd_r))
          begin
            st_r <= sfc_pkg::ST_SUS_WAIT;
            lat_r <= 12'h000;
          end
        sfc_pkg::ST_SUS_WAIT:
          if (lat_r == lat_end)
          begin
            st_r <= sfc_pkg::ST_SUSPENDED;
            wel_r <= 1'b0;
          end
          else
            lat_r <= lat_r + 12'h001;
        sfc_pkg::ST_SUSPENDED:
          if (ex_p && is_res(cmd_r))
          begin
            st_r <= sfc_pkg::ST_BUSY;
            wel_r <= 1'b1;
          end
          else if (ex_p && is_pgm(cmd_r) && wel_r)
            st_r <= sfc_pkg::ST_SUS_PGM;
        sfc_pkg::ST_SUS_PGM:
          if (i_op_done)
          begin
            st_r <= sfc_pkg::ST_SUSPENDED;
            wel_r <= 1'b0;
          end
        default: st_r <= sfc_pkg::ST_IDLE;
      endcase
      if (ex_p && st_r != sfc_pkg::ST_SUS_PGM && st_r != sfc_pkg::ST_SUS_WAIT
          && (cmd_r == sfc_pkg::OP_WR_ENABLE))
        wel_r <= 1'b1;
      else if (ex_p && cmd_r == sfc_pkg::OP_WR_DISABLE
          && st_r != sfc_pkg::ST_SUS_PGM)
        wel_r <= 1'b0;
    end
  end

  // ******************************
  // array engine strobes and status
  // ******************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pgm_go <= 1'b0;
      o_suspend_go <= 1'b0;
      o_resume_go <= 1'b0;
      o_abort <= 1'b0;
      o_array_read <= 1'b0;
    end
    else
    begin
      o_pgm_go <= ex_p && is_pgm(cmd_r) && wel_r && !soft_rst;
      o_suspend_go <= ex_p && is_sus(cmd_r);
      o_resume_go <= ex_p && is_res(cmd_r);
      o_abort <= soft_rst && st_r != sfc_pkg::ST_IDLE;
      o_array_read <= dec_p && accept(op_now) && is_array_read(op_now);
    end
  end
  logic write_in_progress, pgm_sus, ers_sus;
  assign write_in_progress = st_r == sfc_pkg::ST_BUSY || st_r == sfc_pkg::ST_SUS_PGM;
  assign pgm_sus = st_r == sfc_pkg::ST_SUSPENDED && !ers_r;
  assign ers_sus = (st_r == sfc_pkg::ST_SUSPENDED
    || st_r == sfc_pkg::ST_SUS_PGM) && ers_r;
  always_comb
  begin
    status = 16'h0000;
    status[sfc_pkg::ST_WIP_BIT] = write_in_progress;
    status[sfc_pkg::ST_WEL_BIT] = wel_r;
    status[sfc_pkg::ST_ERS_SUS_BIT] = ers_sus;
    status[sfc_pkg::ST_PGM_SUS_BIT] = pgm_sus;
  end
  assign o_status = status;
  assign o_write_enable_latch = wel_r;
  assign o_write_in_progress = write_in_progress;
  assign o_guard_region = pgm_sus || ers_sus;

  // ******************************
  // assertions
  // ******************************
  property p_id_busy;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (dec_p && op_now == sfc_pkg::OP_JEDEC_ID && st_r == sfc_pkg::ST_BUSY)
      |=> !out_en_r;
  endproperty
  a_id_busy: assert property (p_id_busy) else $error("id served busy");
  property p_cs_stop;
    @(posedge i_sys_clk) disable iff (!i_rst_n) cs_s2_r |-> o_so_oe_n;
  endproperty
  a_cs_stop: assert property (p_cs_stop) else $error("driven idle");
  property p_sus_lat;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_r == sfc_pkg::ST_SUS_WAIT && lat_r == lat_end && !soft_rst)
      |=> (pgm_sus || ers_sus) && !wel_r;
  endproperty
  a_sus_lat: assert property (p_sus_lat) else $error("suspend latency");
  property p_resume;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (ex_p && is_res(cmd_r) && st_r == sfc_pkg::ST_SUSPENDED && !soft_rst)
      |=> wel_r && write_in_progress && !pgm_sus && !ers_sus;
  endproperty
  a_resume: assert property (p_resume) else $error("resume flags");
  property p_spgm;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    st_r == sfc_pkg::ST_SUS_PGM |-> wel_r && write_in_progress && o_status[10];
  endproperty
  a_spgm: assert property (p_spgm) else $error("suspend program flags");
  property p_reset;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    soft_rst |=> st_r == sfc_pkg::ST_IDLE && !wel_r && !armed_r;
  endproperty
  a_reset: assert property (p_reset) else $error("reset defaults");
  property p_disarm;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (cs_rise && !(cmd_ok_r && cmd_r == sfc_pkg::OP_RESET_ARM)) |=> !armed_r;
  endproperty
  a_disarm: assert property (p_disarm) else $error("reset stays armed");
  property p_write_enable_cmd_psus;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (pgm_sus && !wel_r && !$past(wel_r))
      ##1 (ex_p && cmd_r == sfc_pkg::OP_WR_ENABLE) |=> !wel_r;
  endproperty
  a_write_enable_cmd_psus: assert property (p_write_enable_cmd_psus) else $error("wel set");
  property p_pgm_bit;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(pgm_sus) |-> $past(st_r) == sfc_pkg::ST_SUS_WAIT && o_status[15];
  endproperty
  a_pgm_bit: assert property (p_pgm_bit) else $error("program flag");
endmodule
`default_nettype wire

/* File: tb/sfc_host_model.sv */
// host serial controller model driving select, clock and data
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
  // serial pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe_n
);
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b0;
  end
  // one framed transfer: opcode, filler bits, then read bits
  task automatic frame(input logic [7:0] op, input int dummy,
    input int nrd, output logic [127:0] rd, output logic drove);
    int i;
    rd = '0;
    drove = 1'b0;
    o_cs_n = 1'b0;
    #100;
    for (i = 0; i < 8 + dummy + nrd; i++)
    begin
      o_si = (i < 8) ? op[7 - i] : ~o_si;
      #62;
      o_sclk = 1'b1;
      if (i >= 8 + dummy)
      begin
        rd = {rd[126:0], i_so};
        drove = drove | ~i_so_oe_n;
      end
      #63;
      o_sclk = 1'b0;
    end
    #60;
    o_cs_n = 1'b1;
    o_si = ~o_si;
  endtask
endmodule
`default_nettype wire

/* File: tb/sfc_cmd_core_tb.sv */
// self-checking bench for the flash command interpreter
`timescale 1ns/1ps
`default_nettype none
module sfc_cmd_core_tb;
  localparam logic [7:0] MAKER = 8'hC3; // arbitrary value
  localparam logic [15:0] DEVICE = 16'h7E21; // arbitrary value
  localparam logic [127:0] SERIAL =
    128'hA5C3_0F96_1E2D_3C4B_5A69_7887_9600_FF11;
  localparam int LAT = sfc_pkg::ERS_SUS_LAT_CYC;
  logic sys_clk, rst_n, ers_start, op_done, cs_n, sclk, si, so, so_oe_n;
  logic pgm_go, suspend_go, resume_go, abort, array_read, guard_region;
  logic write_enable_latch, write_in_progress, drove, eps, ees, ewel, ewip;
  logic [15:0] status;
  logic [127:0] rd;
  int failures, checks, n, k, reads;
  int unsigned seed;
  sfc_cmd_core #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE),
    .SERIAL_NUMBER(SERIAL)) i_dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_si(si), .o_so(so), .o_so_oe_n(so_oe_n), .i_ers_start(ers_start),
    .i_op_done(op_done), .o_pgm_go(pgm_go), .o_suspend_go(suspend_go),
    .o_resume_go(resume_go), .o_abort(abort), .o_array_read(array_read),
    .o_guard_region(guard_region), .o_status(status),
    .o_write_enable_latch(write_enable_latch), .o_write_in_progress(write_in_progress));
  sfc_host_model i_host (.o_cs_n(cs_n), .o_sclk(sclk), .o_si(si),
    .i_so(so), .i_so_oe_n(so_oe_n));
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  // counts accepted array reads
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      reads <= 0;
    else if (array_read === 1'b1)
      reads <= reads + 1;
  end
  // **********
  // checking
  // **********
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic miss(input logic [127:0] got, input logic [127:0] exp);
    failures++;
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
  endtask
  task automatic cmp_data(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp)
      miss(got, exp);
  endtask
  task automatic cmp_flags;
    checks++;
    if ({status[15], status[10], status[1], status[0], write_enable_latch, write_in_progress} !==
      {eps, ees, ewel, ewip, ewel, ewip})
      miss({status[15], status[10], status[1], status[0], write_enable_latch, write_in_progress},
        {eps, ees, ewel, ewip, ewel, ewip});
  endtask
  function automatic logic sig(input int which);
    case (which)
      0: return pgm_go;
      1: return suspend_go;
      2: return resume_go;
      3: return status[10];
      4: return status[15];
      default: return abort;
    endcase
  endfunction
  task automatic wait_hi(input int which, input int limit);
    n = 0;
    while (sig(which) !== 1'b1 && n < limit)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (sig(which) !== 1'b1)
    begin
      miss(128'h0, 128'h1);
      conclude();
    end
  endtask
  // **********
  // stimulus
  // **********
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmd(input logic [7:0] op, input int dummy, input int which);
    i_host.frame(op, dummy, 0, rd, drove);
    if (which >= 0)
      wait_hi(which, 20);
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  task automatic rd_frame(input logic [7:0] op, input int dummy,
    input int nrd);
    i_host.frame(op, dummy, nrd, rd, drove);
    repeat (6) @(posedge sys_clk);
    #1;
    cmp_data({127'h0, so_oe_n}, 128'h1);
  endtask
  task automatic pulse_in(input int which);
    @(posedge sys_clk);
    #1;
    if (which == 0)
      ers_start = 1'b1;
    else
      op_done = 1'b1;
    @(posedge sys_clk);
    #1;
    ers_start = 1'b0;
    op_done = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  initial
  begin
    rst_n = 1'b0;
    ers_start = 1'b0;
    op_done = 1'b0;
    failures = 0;
    checks = 0;
    seed = 88;
    {eps, ees, ewel, ewip} = 4'h0;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    cmp_flags();
    rd_frame(sfc_pkg::OP_JEDEC_ID, 0, 24);
    cmp_data(rd, {104'h0, MAKER, DEVICE});
    for (k = 0; k < 3; k++)
    begin
      n = 1 + int'(xs() % 23);
      rd_frame(sfc_pkg::OP_JEDEC_ID, 0, n);
      cmp_data(rd, {104'h0, MAKER, DEVICE} >> (24 - n));
    end
    rd_frame(sfc_pkg::OP_SERIAL_NUM, 32, 128);
    cmp_data(rd, SERIAL);
    $display("identity and serial reads done");
    cmd(sfc_pkg::OP_WR_ENABLE, 0, -1);
    pulse_in(0);
    {ewel, ewip} = 2'h3;
    rd_frame(sfc_pkg::OP_JEDEC_ID, 0, 24);
    cmp_data({127'h0, drove}, 128'h0);
    cmp_flags();
    cmd(sfc_pkg::OP_READ, 24, -1);
    cmp_data(128'(reads), 128'h0);
    cmd(sfc_pkg::OP_SUSPEND_A, 0, 1);
    wait_hi(3, LAT + 100);
    cmp_data(128'(n >= LAT - 10 && n <= LAT + 10), 128'h1);
    {ees, ewel, ewip} = 3'h4;
    cmp_flags();
    cmp_data({127'h0, guard_region}, 128'h1);
    rd_frame(sfc_pkg::OP_STAT_HI, 0, 8);
    cmp_data(rd, {120'h0, eps, 4'h0, ees, 2'h0});
    cmd(sfc_pkg::OP_WR_ENABLE, 0, -1);
    ewel = 1'b1;
    cmp_flags();
    cmd(sfc_pkg::OP_PAGE_PGM, 32, 0);
    ewip = 1'b1;
    cmp_flags();
    rd_frame(sfc_pkg::OP_STAT_LO, 0, 8);
    cmp_data(rd, {120'h0, 6'h0, ewel, ewip});
    cmd(sfc_pkg::OP_SUSPEND_B, 0, -1);
    cmp_flags();
    pulse_in(1);
    {ewel, ewip} = 2'h0;
    cmp_flags();
    cmd(sfc_pkg::OP_RESUME_A, 0, 2);
    {ees, ewel, ewip} = 3'h3;
    cmp_flags();
    pulse_in(1);
    {ewel, ewip} = 2'h0;
    $display("erase suspend test done");
    cmd(sfc_pkg::OP_WR_ENABLE, 0, -1);
    cmd(sfc_pkg::OP_PAGE_PGM, 32, 0);
    repeat (400) @(posedge sys_clk);
    #1;
    cmd(sfc_pkg::OP_SUSPEND_A, 0, 1);
    wait_hi(4, LAT + 100);
    eps = 1'b1;
    cmp_flags();
    cmd(sfc_pkg::OP_WR_ENABLE, 0, -1);
    cmp_flags();
    rd_frame(sfc_pkg::OP_JEDEC_ID, 0, 24);
    cmp_data(rd, {104'h0, MAKER, DEVICE});
    cmd(sfc_pkg::OP_READ, 24, -1);
    cmp_data(128'(reads), 128'h1);
    cmd(sfc_pkg::OP_RESUME_B, 0, 2);
    {eps, ewel, ewip} = 3'h3;
    cmp_flags();
    pulse_in(1);
    {ewel, ewip} = 2'h0;
    $display("program suspend test done");
    cmd(sfc_pkg::OP_WR_ENABLE, 0, -1);
    cmd(sfc_pkg::OP_RESET_ARM, 0, -1);
    cmd(sfc_pkg::OP_NO_OP, 0, -1);
    cmd(sfc_pkg::OP_RESET, 0, -1);
    ewel = 1'b1;
    cmp_flags();
    cmd(sfc_pkg::OP_RESET_ARM, 0, -1);
    cmd(sfc_pkg::OP_RESET, 0, -1);
    ewel = 1'b0;
    cmp_flags();
    cmd(sfc_pkg::OP_WR_ENABLE, 0, -1);
    pulse_in(0);
    cmd(sfc_pkg::OP_RESET_ARM, 0, -1);
    cmd(sfc_pkg::OP_RESET, 0, 5);
    cmp_flags();
    cmp_data({127'h0, guard_region}, 128'h0);
    $display("software reset test done");
    conclude();
  end
endmodule
`default_nettype wire
